// >>> eib_input_bank.sv
// Read-only input register bank of the linear encoder slave.
// Assumes a frame decoder on clk_sys_i that issues one word read at a time.
`timescale 1ns/1ps

module eib_input_bank #(
  parameter int unsigned TICK_CYC = eib_pkg::TICK_CYC,
  parameter int unsigned WDOG_TIMEOUT_MS = eib_pkg::WDOG_TIMEOUT_MS,
  parameter logic [15:0] FW_VERSION = eib_pkg::FW_VERSION_RST,
  parameter logic [15:0] BOARD_EDITION = eib_pkg::BOARD_EDITION_RST
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // Register access from frame decoder
  input wire logic rd_req_i,
  input wire logic [15:0] rd_addr_i,
  input wire logic wr_req_i,
  output logic rd_ack_o,
  output logic rd_err_o,
  output logic [eib_pkg::WORD_W-1:0] rd_data_o,
  output logic wr_refused_o,
  // Bus activity and control word
  input wire logic msg_rx_i,
  input wire logic wdog_en_i,
  // Stored settings
  input wire logic [eib_pkg::OP_W-1:0] op_params_i,
  input wire logic [eib_pkg::MAP_W-1:0] bad_setting_i,
  // Measurement faults and position
  input wire logic signed [15:0] position_i,
  input wire logic flash_fault_i,
  input wire logic hall_fault_i,
  input wire logic mount_fault_i,
  // Diagnostic indicator
  output logic led_fault_o
);

  import eib_pkg::*;

  localparam int unsigned MSW = (WDOG_TIMEOUT_MS > 1) ?
    $clog2(WDOG_TIMEOUT_MS) : 1;
  localparam logic [MSW-1:0] MS_LAST = MSW'(WDOG_TIMEOUT_MS - 1);

  logic [WORD_W-1:0] alarm_flags;
  logic cfg_alarm;
  logic flash_alarm;
  logic hall_alarm;
  logic mount_alarm;
  logic wdog_alarm;
  logic [WORD_W-1:0] bad_map_word;
  logic [WORD_W-1:0] state_word;
  logic [WORD_W-1:0] next_rd_data;
  logic next_rd_err;
  logic ms_tick;
  logic wdog_clr;
  logic wdog_expire;
  logic [MSW-1:0] ms_cnt;

  // --------------------------------------------------------------------
  // Watchdog time base
  // --------------------------------------------------------------------
  // Any message or a disabled watchdog restarts the whole timeout
  assign wdog_clr = msg_rx_i || !wdog_en_i;

  eib_tick_div #(
    .DIV(TICK_CYC)
  ) u_ms_div (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .clr_i(wdog_clr),
    .tick_o(ms_tick)
  );

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ms_cnt <= '0;
    end else if (wdog_clr || (ms_tick && ms_cnt == MS_LAST)) begin
      ms_cnt <= '0;
    end else if (ms_tick) begin
      ms_cnt <= ms_cnt + MSW'(1);
    end
  end

  // Enable comes straight from control word bit 8
  assign wdog_expire = wdog_en_i && ms_tick && ms_cnt == MS_LAST;

  // --------------------------------------------------------------------
  // Alarm word
  // --------------------------------------------------------------------
  // Settings are live inputs; unsaved values vanish with the reset
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cfg_alarm <= 1'b0;
    end else begin
      cfg_alarm <= |bad_setting_i;
    end
  end

  // Memory fault only leaves at power-on reset
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      flash_alarm <= 1'b0;
    end else if (flash_fault_i) begin
      flash_alarm <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hall_alarm <= 1'b0;
      mount_alarm <= 1'b0;
    end else begin
      hall_alarm <= hall_fault_i;
      mount_alarm <= mount_fault_i;
    end
  end

  // Timeout wins over a message in the same cycle
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wdog_alarm <= 1'b0;
    end else if (wdog_expire) begin
      wdog_alarm <= 1'b1;
    end else if (wdog_clr) begin
      wdog_alarm <= 1'b0;
    end
  end

  // Word assembly; unused alarm positions stay zero
  always_comb begin
    alarm_flags = ALARM_RST;
    alarm_flags[ALM_CFG_BIT] = cfg_alarm;
    alarm_flags[ALM_FLASH_BIT] = flash_alarm;
    alarm_flags[ALM_HALL_BIT] = hall_alarm;
    alarm_flags[ALM_MOUNT_BIT] = mount_alarm;
    alarm_flags[ALM_WDOG_BIT] = wdog_alarm;
  end

  // --------------------------------------------------------------------
  // Diagnostic indicator
  // --------------------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      led_fault_o <= 1'b0;
    end else begin
      led_fault_o <= |alarm_flags;
    end
  end

  // --------------------------------------------------------------------
  // Derived words
  // --------------------------------------------------------------------
  always_comb begin
    bad_map_word = '0;
    bad_map_word[MAP_LO_BIT +: MAP_W] = bad_setting_i;
  end

  // Low byte mirrors settings: bit 0 scaling, bit 1 direction
  always_comb begin
    state_word = '0;
    state_word[OP_W-1:0] = op_params_i;
    state_word[ST_ALARM_BIT] = |alarm_flags;
  end

  // --------------------------------------------------------------------
  // Read decode
  // --------------------------------------------------------------------
  always_comb begin
    next_rd_data = RESERVED_VALUE;
    next_rd_err = 1'b0;
    case (rd_addr_i)
      ADDR_ALARM: next_rd_data = alarm_flags;
      ADDR_POSITION: next_rd_data = position_i;
      ADDR_SPEED: next_rd_data = RESERVED_VALUE;
      ADDR_BAD_MAP: next_rd_data = bad_map_word;
      ADDR_FW: next_rd_data = FW_VERSION;
      ADDR_HW: next_rd_data = BOARD_EDITION;
      ADDR_STATE: next_rd_data = state_word;
      default: next_rd_err = 1'b1;
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_ack_o <= 1'b0;
      rd_err_o <= 1'b0;
    end else begin
      rd_ack_o <= rd_req_i;
      rd_err_o <= rd_req_i && next_rd_err;
    end
  end

  // Data held until the next read
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_data_o <= '0;
    end else if (rd_req_i) begin
      rd_data_o <= next_rd_data;
    end
  end

  // --------------------------------------------------------------------
  // Write refusal
  // --------------------------------------------------------------------
  // Writes never touch any word; decoder answers with an exception
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_refused_o <= 1'b0;
    end else begin
      wr_refused_o <= wr_req_i;
    end
  end

  // --------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_wdog_timeout;
    wdog_en_i && ms_tick && ms_cnt == MS_LAST;
  endsequence

  sequence s_msg_resume;
    msg_rx_i && !wdog_expire;
  endsequence

  chk_write_refused: assert property (
    wr_req_i |=> wr_refused_o)
    else $error("write not refused");

  chk_write_no_effect: assert property (
    wr_req_i && !rd_req_i |=> $stable(rd_data_o) && wr_refused_o)
    else $error("write changed read data");

  chk_cfg_alarm: assert property (
    |bad_setting_i |=> alarm_flags[ALM_CFG_BIT])
    else $error("invalid setting not flagged");

  chk_cfg_alarm_clear: assert property (
    bad_setting_i == '0 |=> !alarm_flags[ALM_CFG_BIT])
    else $error("settings alarm stuck after valid values");

  chk_flash_sticky: assert property (
    alarm_flags[ALM_FLASH_BIT] |=> alarm_flags[ALM_FLASH_BIT] [*4])
    else $error("memory fault alarm cleared");

  chk_hall_alarm: assert property (
    hall_fault_i |=> alarm_flags[ALM_HALL_BIT])
    else $error("Hall fault not flagged");

  chk_mount_alarm: assert property (
    !mount_fault_i |=> !alarm_flags[ALM_MOUNT_BIT])
    else $error("mounting alarm without cause");

  chk_led_fault: assert property (
    |alarm_flags |=> led_fault_o)
    else $error("indicator missed an alarm");

  chk_wdog_set: assert property (
    s_wdog_timeout |=> alarm_flags[ALM_WDOG_BIT])
    else $error("watchdog timeout not flagged");

  chk_wdog_clear: assert property (
    s_msg_resume |=> !alarm_flags[ALM_WDOG_BIT])
    else $error("watchdog alarm kept after message");

  chk_wdog_quiet: assert property (
    msg_rx_i && wdog_en_i && !wdog_expire |=>
    !ms_tick ##1 !alarm_flags[ALM_WDOG_BIT])
    else $error("watchdog fired right after message");

  chk_pos_read: assert property (
    rd_req_i && rd_addr_i == ADDR_POSITION |=>
    rd_ack_o && !rd_err_o && rd_data_o == $past(position_i))
    else $error("position read wrong");

  chk_speed_zero: assert property (
    rd_req_i && rd_addr_i == ADDR_SPEED |=> rd_data_o == RESERVED_VALUE)
    else $error("reserved word not zero");

  chk_map_read: assert property (
    rd_req_i && rd_addr_i == ADDR_BAD_MAP |=>
    rd_data_o == {9'h000, $past(bad_setting_i), 1'b0})
    else $error("invalid-setting map wrong");

  chk_version_read: assert property (
    rd_req_i && (rd_addr_i == ADDR_FW || rd_addr_i == ADDR_HW) |=>
    rd_data_o == ($past(rd_addr_i) == ADDR_FW ? FW_VERSION : BOARD_EDITION))
    else $error("version word wrong");

  chk_state_read: assert property (
    rd_req_i && rd_addr_i == ADDR_STATE |=>
    rd_data_o == {7'h00, $past(|alarm_flags), $past(op_params_i)})
    else $error("status word wrong");

  chk_state_bits: assert property (
    rd_req_i && rd_addr_i == ADDR_STATE |=>
    rd_data_o[ST_SCALE_BIT] == $past(op_params_i[0]) &&
    rd_data_o[ST_DIR_BIT] == $past(op_params_i[1]))
    else $error("scaling or direction bit wrong");

  chk_alarm_unused: assert property (
    rd_req_i && rd_addr_i == ADDR_ALARM |=>
    (rd_data_o & 16'hF7F0) == 16'h0000)
    else $error("unused alarm bits set");

  chk_bad_addr: assert property (
    rd_req_i && rd_addr_i > ADDR_STATE |=> rd_ack_o && rd_err_o &&
    rd_data_o == RESERVED_VALUE)
    else $error("unmapped address not refused");

endmodule // eib_input_bank

// >>> eib_mst.sv
// Field-bus master model on the decoder side of the input bank.
// Assumes the bench calls one task at a time.
`timescale 1ns/1ps

module eib_mst (
  // Clock
  input wire logic clk_sys_i,
  // Requests to the bank
  output logic rd_req_o,
  output logic [15:0] rd_addr_o,
  output logic wr_req_o,
  output logic msg_rx_o,
  output logic wdog_en_o,
  // Answers from the bank
  input wire logic rd_ack_i,
  input wire logic rd_err_i,
  input wire logic [15:0] rd_data_i,
  input wire logic wr_refused_i
);
  logic [15:0] q_data [$];
  logic q_ack [$];
  logic q_err [$];
  logic refused;

  initial begin
    rd_req_o = 1'b0;
    rd_addr_o = 16'h0000;
    wr_req_o = 1'b0;
    msg_rx_o = 1'b0;
    wdog_en_o = 1'b0;
  end

  // Read of n words, one per cycle; idle address is not held
  task automatic read_words(input logic [15:0] start, input int n);
    q_data.delete();
    q_ack.delete();
    q_err.delete();
    @(posedge clk_sys_i);
    #1;
    for (int k = 0; k <= n; k++) begin
      rd_req_o = k < n;
      rd_addr_o = k < n ? start + 16'(k) : ~rd_addr_o;
      @(posedge clk_sys_i);
      #1;
      if (k < n) begin
        q_data.push_back(rd_data_i);
        q_ack.push_back(rd_ack_i);
        q_err.push_back(rd_err_i);
      end
    end
  endtask

  // One message pulse, or one write attempt
  task automatic pulse(input bit msg);
    @(posedge clk_sys_i);
    #1;
    if (msg) msg_rx_o = 1'b1;
    else wr_req_o = 1'b1;
    @(posedge clk_sys_i);
    #1;
    msg_rx_o = 1'b0;
    wr_req_o = 1'b0;
    refused = wr_refused_i;
  endtask

  task automatic set_wdog(input logic en);
    @(posedge clk_sys_i);
    #1;
    wdog_en_o = en;
  endtask
endmodule // eib_mst

// >>> eib_pkg.sv
// Constants for the encoder input register bank.
// Assumes one 25 MHz system clock and a frame decoder on the same clock.
//
// Function
// - Input registers are read-only; reads use function 04, writes change nothing.
// - Alarm bit 0 set while any stored setting is invalid.
// - Alarm bit 1 set on memory fault and held until reset.
// - Alarm bit 2 set when the Hall sensor scale reading fails.
// - Alarm bit 3 set when head sits beyond allowed gap from scale.
// - Diagnostic indicator shows fault while any alarm bit is active.
// - With watchdog enabled, alarm bit 11 set after 1 s without messages.
// - Watchdog alarm clears by itself once communication resumes.
// - Invalid-settings alarm stays until the master writes valid values.
// - Register 0001 returns the signed 16-bit scaled present position.
// - Register 0002 is reserved; no velocity function.
// - Register 0003 flags invalid settings on bits 1 to 6.
// - Register 0004 holds firmware edition high byte, revision low byte.
// - Register 0005 holds board edition high byte, revision low byte.
// - Status low byte mirrors operating settings; bit 8 shows any alarm.
// - Status bit 0 shows whether output scaling is enabled.
// - Settings not saved are lost at power loss; master must save.
// - Status bit 1 shows the configured counting direction.

package eib_pkg;

  // ----------------------------------------------------------------------
  // Word and map layout
  // ----------------------------------------------------------------------
  localparam int unsigned WORD_W = 16;
  localparam logic [15:0] ADDR_ALARM = 16'h0000;
  localparam logic [15:0] ADDR_POSITION = 16'h0001;
  localparam logic [15:0] ADDR_SPEED = 16'h0002;
  localparam logic [15:0] ADDR_BAD_MAP = 16'h0003;
  localparam logic [15:0] ADDR_FW = 16'h0004;
  localparam logic [15:0] ADDR_HW = 16'h0005;
  localparam logic [15:0] ADDR_STATE = 16'h0006;
  localparam logic [15:0] RESERVED_VALUE = 16'h0000;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int unsigned ALM_CFG_BIT = 0;
  localparam int unsigned ALM_FLASH_BIT = 1;
  localparam int unsigned ALM_HALL_BIT = 2;
  localparam int unsigned ALM_MOUNT_BIT = 3;
  localparam int unsigned ALM_WDOG_BIT = 11;
  localparam int unsigned MAP_LO_BIT = 1;
  localparam int unsigned MAP_W = 6;
  localparam int unsigned ST_SCALE_BIT = 0;
  localparam int unsigned ST_DIR_BIT = 1;
  localparam int unsigned ST_ALARM_BIT = 8;
  localparam int unsigned OP_W = 8;

  // ----------------------------------------------------------------------
  // Reset values (version words: edition high byte, revision low byte)
  // ----------------------------------------------------------------------
  localparam logic [15:0] FW_VERSION_RST = 16'h0100;
  localparam logic [15:0] BOARD_EDITION_RST = 16'h0101;
  localparam logic [15:0] ALARM_RST = 16'h0000;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned TICK_US = 1000;
  localparam int unsigned TICK_CYC = CLK_HZ / 1_000_000 * TICK_US;
  localparam int unsigned WDOG_TIMEOUT_MS = 1000;

endpackage

// >>> eib_tick_div.sv
// Divider making a one-cycle enable pulse every DIV clock cycles.
// Assumes clr_i comes from logic on the same clock.
`timescale 1ns/1ps

module eib_tick_div #(
  parameter int unsigned DIV = 25000
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // Control
  input wire logic clr_i,
  // Enable pulse
  output logic tick_o
);

  localparam int unsigned CW = (DIV > 1) ? $clog2(DIV) : 1;
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);

  logic [CW-1:0] cnt;

  // --------------------------------------------------------------------
  // Counter
  // --------------------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt <= '0;
    end else if (clr_i || cnt == LAST) begin
      cnt <= '0;
    end else begin
      cnt <= cnt + CW'(1);
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tick_o <= 1'b0;
    end else begin
      tick_o <= !clr_i && cnt == LAST;
    end
  end

  // --------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------
  chk_tick_after_clear: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n_i) clr_i |=> !tick_o)
    else $error("tick followed a clear");

endmodule // eib_tick_div

// >>> testbench.sv
// Self-checking bench for the encoder input register bank.
// Assumes eib_pkg and the master model eib_mst are compiled first.
`timescale 1ns/1ps

module testbench;
  import eib_pkg::*;
  localparam logic [15:0] FW = 16'h0203;
  localparam logic [15:0] HW = 16'h0405;
  logic clk = 1'b0;
  logic rst_n;
  logic rd_req, wr_req, msg_rx, wdog_en, rd_ack, rd_err, wr_ref, led;
  logic [15:0] rd_addr, rd_data;
  logic [7:0] op;
  logic [5:0] bad;
  logic signed [15:0] pos;
  logic flash, hall, mount;
  logic flash_exp = 1'b0, wd_exp = 1'b0;
  int err_total = 0, n_checks = 0, seed = 32'h077f;

  always #20 clk = ~clk;

  eib_input_bank #(.TICK_CYC(4), .WDOG_TIMEOUT_MS(3), .FW_VERSION(FW),
    .BOARD_EDITION(HW)) i_eib_input_bank (.clk_sys_i(clk), .rst_n_i(rst_n),
    .rd_req_i(rd_req), .rd_addr_i(rd_addr), .wr_req_i(wr_req),
    .rd_ack_o(rd_ack), .rd_err_o(rd_err), .rd_data_o(rd_data),
    .wr_refused_o(wr_ref), .msg_rx_i(msg_rx), .wdog_en_i(wdog_en),
    .op_params_i(op), .bad_setting_i(bad), .position_i(pos),
    .flash_fault_i(flash), .hall_fault_i(hall), .mount_fault_i(mount),
    .led_fault_o(led));

  eib_mst i_eib_mst (.clk_sys_i(clk), .rd_req_o(rd_req),
    .rd_addr_o(rd_addr), .wr_req_o(wr_req), .msg_rx_o(msg_rx),
    .wdog_en_o(wdog_en), .rd_ack_i(rd_ack), .rd_err_i(rd_err),
    .rd_data_i(rd_data), .wr_refused_i(wr_ref));

  function automatic logic [15:0] exp_alarm();
    logic [15:0] a;
    a = 16'h0000;
    a[ALM_CFG_BIT] = |bad;
    a[ALM_FLASH_BIT] = flash_exp;
    a[ALM_HALL_BIT] = hall;
    a[ALM_MOUNT_BIT] = mount;
    a[ALM_WDOG_BIT] = wd_exp;
    return a;
  endfunction

  function automatic logic [15:0] exp_word(input logic [15:0] a);
    case (a)
      ADDR_ALARM: return exp_alarm();
      ADDR_POSITION: return pos;
      ADDR_BAD_MAP: return {9'h000, bad, 1'b0};
      ADDR_FW: return FW;
      ADDR_HW: return HW;
      ADDR_STATE: return {7'h00, |exp_alarm(), op};
      default: return 16'h0000;
    endcase
  endfunction

  task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_flag(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic check_read(input logic [15:0] start, input int n);
    logic [15:0] a;
    i_eib_mst.read_words(start, n);
    for (int k = 0; k < n; k++) begin
      a = start + 16'(k);
      cmp_flag(i_eib_mst.q_ack[k], 1'b1);
      cmp_flag(i_eib_mst.q_err[k], a > ADDR_STATE);
      cmp_word(i_eib_mst.q_data[k], exp_word(a));
    end
  endtask

  task automatic end_test(input string name);
    $display("test %s done, mismatches so far %0d", name, err_total);
  endtask

  task automatic finish_test();
    $display("checks %0d, mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    #200_000;
    err_total++;
    finish_test();
  end

  initial begin
    rst_n = 1'b0;
    op = 8'h00;
    bad = 6'h00;
    pos = 16'sh0000;
    flash = 1'b0;
    hall = 1'b0;
    mount = 1'b0;
    repeat (12) @(posedge clk);
    #1;
    rst_n = 1'b1;
    check_read(16'h0000, 7);
    check_read(16'h0005, 4);
    check_read(16'hFFFF, 1);
    end_test("map");
    for (int i = 0; i < 40; i++) begin
      op = 8'($random(seed));
      bad = i % 3 == 0 ? 6'($random(seed)) : 6'h00;
      pos = i == 0 ? 16'sh8000 : 16'($random(seed));
      hall = 1'($random(seed));
      mount = 1'($random(seed));
      if (i == 1) begin
        op = 8'hFF;
        bad = 6'h3F;
      end
      tick(3);
      cmp_flag(led, |{bad, hall, mount});
      check_read(16'h0000, 7);
    end
    bad = 6'h00;
    hall = 1'b0;
    mount = 1'b0;
    tick(3);
    cmp_flag(led, 1'b0);
    check_read(16'h0000, 1);
    end_test("random");
    i_eib_mst.pulse(1'b0);
    cmp_flag(i_eib_mst.refused, 1'b1);
    check_read(16'h0000, 7);
    end_test("write");
    i_eib_mst.set_wdog(1'b1);
    i_eib_mst.pulse(1'b1);
    tick(13);
    cmp_flag(led, 1'b0);
    tick(1);
    cmp_flag(led, 1'b1);
    wd_exp = 1'b1;
    check_read(16'h0000, 7);
    // Keep the message off the next timeout edge
    tick(1);
    i_eib_mst.pulse(1'b1);
    wd_exp = 1'b0;
    tick(2);
    cmp_flag(led, 1'b0);
    check_read(16'h0000, 1);
    i_eib_mst.set_wdog(1'b0);
    tick(20);
    cmp_flag(led, 1'b0);
    end_test("watchdog");
    flash = 1'b1;
    tick(1);
    flash = 1'b0;
    flash_exp = 1'b1;
    tick(20);
    cmp_flag(led, 1'b1);
    check_read(16'h0000, 7);
    rst_n = 1'b0;
    tick(2);
    cmp_word(rd_data, 16'h0000);
    cmp_flag(led, 1'b0);
    rst_n = 1'b1;
    flash_exp = 1'b0;
    check_read(16'h0000, 1);
    end_test("flash");
    finish_test();
  end
endmodule // testbench
